// >>> src/lsd_pkg.sv
// Purpose: Shared constants and types of the serial-in LED sink driver
// Assumes: Serial pins arrive asynchronous to mclk
// Notes: Latch bit n drives sink n; one turns the sink on
package lsd_pkg;

	localparam int LSD_WIDTH = 16;
	localparam int LSD_SYNC_STAGES = 2;
	localparam logic [LSD_WIDTH-1:0] LSD_ZERO = 16'h0000;
	localparam logic LSD_LOW = 1'b0;
	localparam logic LSD_HIGH = 1'b1;

	// Serial interface pins after synchronisation
	typedef struct packed {
		logic ser_clk;
		logic ser_in;
		logic latch_load;
		logic out_gate_n;
	} lsd_pins_s;

	localparam int LSD_PIN_BITS = $bits(lsd_pins_s);
	localparam lsd_pins_s LSD_PINS_RST = '{
		ser_clk: LSD_LOW, ser_in: LSD_LOW, latch_load: LSD_LOW, out_gate_n: LSD_HIGH};

	// Whole state of the driver
	typedef struct packed {
		logic clk_prev;
		logic [LSD_WIDTH-1:0] shift;
		logic [LSD_WIDTH-1:0] latch;
		logic ser_out;
		logic [LSD_WIDTH-1:0] sink_oe;
		logic [LSD_WIDTH-1:0] sink_o;
	} lsd_state_s;

	localparam lsd_state_s LSD_STATE_RST = '{
		clk_prev: LSD_LOW, shift: LSD_ZERO, latch: LSD_ZERO, ser_out: LSD_LOW,
		sink_oe: LSD_ZERO, sink_o: LSD_ZERO};

endpackage

// >>> src/lsd_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pins
// Assumes: Each bit is an independent level
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
module lsd_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins in and synchronised levels out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// >>> src/lsd_driver.sv
// Purpose: Shift register, output latch and gated open-drain sinks of an LED driver
// Assumes: mclk at 25 MHz, serial clock far slower and sampled on mclk
// Notes: Hold ser_clk low through reset so no false edge is seen
// Notes: Latch copy lags the shift register by one mclk while load is high
// Functional notes
// - Each serial clock rise shifts the serial input into a 16-bit register.
// - Register advances only on serial clock rise; host presents bits then.
// - While latch load is high, the latch follows the shift register.
// - Latch load falling captures the shift value; held while low.
// - Gate high releases all sinks; latch contents stay unchanged.
// - Gate low lets each sink follow its latch bit.
// - Serial output shows the last shift stage, updated on each rise.
// - Sixteen independent open-drain sinks, one per latch bit.
// - Words arrive first_bit first, last_bit last, sixteen bits each.
// - Serial input appears at serial output sixteen clocks later.
// - Gate level never affects shifting or latching.
// - At power-up latches are clear so all sinks are off.
`timescale 1ns/1ps
module lsd_driver
	import lsd_pkg::*;
#(
	parameter int WIDTH = LSD_WIDTH
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Serial interface pins
	input wire logic ser_clk,
	input wire logic ser_in,
	input wire logic latch_load,
	input wire logic out_gate_n,
	output logic ser_out,
	// Open-drain LED sinks
	output logic [WIDTH-1:0] led_sink_o,
	output logic [WIDTH-1:0] led_sink_oe
);

	// Refuse widths the packed state cannot hold
	if (WIDTH != LSD_WIDTH) begin : g_width_check
		$error("lsd_driver supports only the documented width");
	end

	localparam int TOP = WIDTH - 1;

	// Edge decode shared by the update logic and the checks
	function automatic logic rose_now(input logic cur, input logic prev);
		return cur && !prev;
	endfunction

	// Gate pin is active low; high releases every sink
	function automatic logic gate_open(input logic gate_n);
		return !gate_n;
	endfunction

	lsd_pins_s pins_in;
	lsd_pins_s pins_s;
	lsd_state_s st_q;
	lsd_state_s st_d;
	logic clk_rise;
	wire logic [WIDTH-1:0] shift_nx;
	wire logic [WIDTH-1:0] sink_on;

	assign pins_in = '{ser_clk: ser_clk, ser_in: ser_in, latch_load: latch_load,
		out_gate_n: out_gate_n};

	lsd_sync #(
		.W(LSD_PIN_BITS),
		.RST_VAL(LSD_PINS_RST)
	) u_sync (
		.clk(mclk),
		.rst_n(nrst),
		.async_in(pins_in),
		.sync_out(pins_s)
	);

	assign clk_rise = rose_now(pins_s.ser_clk, st_q.clk_prev);

	// Next shift value: first_bit enters stage 0 and climbs toward the top
	assign shift_nx[0] = pins_s.ser_in;
	for (genvar s = 1; s < WIDTH; s++) begin : g_stage
		assign shift_nx[s] = st_q.shift[s-1];
		stage_move_a: assert property (@(posedge mclk) disable iff (!nrst)
			clk_rise |=> st_q.shift[s] == $past(st_q.shift[s-1]))
			else $error("Shift stage did not take its lower neighbour");
	end

	// One enable per sink: latch bit n under the active-low gate
	for (genvar n = 0; n < WIDTH; n++) begin : g_sink
		assign sink_on[n] = st_q.latch[n] && gate_open(pins_s.out_gate_n);
		sink_bit_a: assert property (@(posedge mclk) disable iff (!nrst)
			1'b1 |=> led_sink_oe[n] == ($past(st_q.latch[n]) && $past(!pins_s.out_gate_n)))
			else $error("Sink does not follow its own latch bit");
		sink_off_a: assert property (@(posedge mclk) disable iff (!nrst)
			pins_s.out_gate_n |=> !led_sink_oe[n])
			else $error("Sink enabled while gate is high");
	end

	always_comb begin
		st_d = st_q;
		st_d.clk_prev = pins_s.ser_clk;
		// Shift toward the top so the first bit ends in the top stage
		if (clk_rise) begin
			st_d.shift = shift_nx;
		end
		st_d.ser_out = st_q.shift[WIDTH-1];
		// Transparent while high, frozen while low
		if (pins_s.latch_load) begin
			st_d.latch = st_q.shift;
		end
		st_d.sink_oe = sink_on;
		st_d.sink_o = LSD_ZERO;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_q <= LSD_STATE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign ser_out = st_q.ser_out;
	assign led_sink_o = st_q.sink_o;
	assign led_sink_oe = st_q.sink_oe;

	// All checks below live in the mclk domain
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence rise_seen;
		rose_now(pins_s.ser_clk, st_q.clk_prev);
	endsequence

	// Load pin just went low and stays low one more cycle
	sequence load_dropped;
		$fell(pins_s.latch_load) ##0 (!pins_s.latch_load)[*2];
	endsequence

	// A serial clock rise, then a cycle with none
	sequence rise_then_quiet;
		rise_seen ##1 !clk_rise;
	endsequence

	// Two cycles with no serial clock rise
	sequence two_quiet;
		!clk_rise ##1 !clk_rise;
	endsequence

	shift_advance_a: assert property (rise_seen |=>
		st_q.shift == {$past(st_q.shift[WIDTH-2:0]), $past(pins_s.ser_in)})
		else $error("Shift register did not take serial input on rise");

	shift_hold_a: assert property (!clk_rise |=> $stable(st_q.shift))
		else $error("Shift register moved without a serial clock rise");

	latch_follow_a: assert property (pins_s.latch_load |=>
		st_q.latch == $past(st_q.shift))
		else $error("Latch did not follow shift register while loading");

	latch_hold_a: assert property (load_dropped
		|-> $stable(st_q.latch))
		else $error("Latch changed while load is low");

	gate_off_a: assert property (pins_s.out_gate_n |=> led_sink_oe == LSD_ZERO)
		else $error("Sink driven while gate is high");

	gate_on_a: assert property (!pins_s.out_gate_n |=> led_sink_oe == $past(st_q.latch))
		else $error("Sinks do not follow latch while gate is low");

	ser_out_a: assert property (rise_then_quiet |=>
		ser_out == $past(st_q.shift[WIDTH-1]))
		else $error("Serial output does not show last stage");

	sink_level_a: assert property (led_sink_o == LSD_ZERO)
		else $error("Sink output level is not low");

	gate_indep_a: assert property (pins_s.out_gate_n && pins_s.latch_load |=>
		st_q.latch == $past(st_q.shift))
		else $error("Gate disturbed latching");

	prev_track_a: assert property (1'b1 |=>
		st_q.clk_prev == $past(pins_s.ser_clk))
		else $error("Rise detector lost the serial clock level");

	pin_sync_a: assert property (1'b1 |-> ##2
		pins_s == $past(pins_in, 2))
		else $error("Pins not seen two cycles after they change");

	ser_out_track_a: assert property (1'b1 |=>
		ser_out == $past(st_q.shift[TOP]))
		else $error("Serial output is not the top stage");

	quiet_out_a: assert property (two_quiet |=>
		$stable(ser_out))
		else $error("Serial output moved without a rise");

	latch_idle_a: assert property (!pins_s.latch_load |=>
		$stable(st_q.latch))
		else $error("Latch moved while load is low");

	load_rise_a: assert property ($rose(pins_s.latch_load) |=>
		st_q.latch == $past(st_q.shift))
		else $error("Latch missed the shift value on load rise");

	gate_keep_a: assert property (pins_s.out_gate_n && !pins_s.latch_load |=>
		$stable(st_q.latch))
		else $error("Gate high altered latch contents");

	gate_shift_a: assert property (pins_s.out_gate_n && clk_rise |=>
		st_q.shift == {$past(st_q.shift[TOP-1:0]), $past(pins_s.ser_in)})
		else $error("Gate disturbed shifting");

	load_sink_a: assert property (pins_s.latch_load && gate_open(pins_s.out_gate_n)
		##1 gate_open(pins_s.out_gate_n) |=> led_sink_oe == $past(st_q.shift, 2))
		else $error("Loaded word did not reach the sinks");

	sink_mask_a: assert property (1'b1 |=>
		(led_sink_oe & ~$past(st_q.latch)) == LSD_ZERO)
		else $error("Sink on while its latch bit is zero");

	// Runs while reset holds, so it opts out of the default disable
	reset_clear_a: assert property (@(posedge mclk) disable iff (1'b0)
		(!nrst)[*2] |-> st_q.latch == LSD_ZERO && led_sink_oe == LSD_ZERO && !ser_out)
		else $error("Outputs not clear during reset");

endmodule

// >>> dv/lsd_host_model.sv
// Purpose: Host that shifts words into the LED driver
// Assumes: Link clock 320 ns, changed on mclk falling edges
// Notes: Records serial output sampled just before each rise
`timescale 1ns/1ps
module lsd_host_model (
	// Clock
	input wire logic mclk,
	// Serial link
	input wire logic ser_out,
	output logic ser_clk,
	output logic ser_in
);
	logic [15:0] seen;
	initial begin
		ser_clk = 1'b0;
		ser_in = 1'b0;
		seen = 16'h0000;
	end
	task automatic send(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			@(negedge mclk);
			ser_in = w[i];
			repeat (3) @(negedge mclk);
			seen = {seen[14:0], ser_out};
			ser_clk = 1'b1;
			repeat (4) @(negedge mclk);
			ser_clk = 1'b0;
		end
		repeat (4) @(negedge mclk);
		// Released data line must not keep the last bit
		ser_in = ~ser_in;
	endtask
endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench of the LED driver
// Assumes: Gate pin starts low so latch shows
// Notes: Host model drives the serial link
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	logic mclk, nrst, latch_load, out_gate_n, ser_clk, ser_in, ser_out;
	logic [15:0] sink_o, sink_oe;
	int fails = 0;
	int n_compared = 0;
	lsd_driver lsd_driver_inst (.mclk(mclk), .nrst(nrst), .ser_clk(ser_clk),
		.ser_in(ser_in), .latch_load(latch_load), .out_gate_n(out_gate_n),
		.ser_out(ser_out), .led_sink_o(sink_o), .led_sink_oe(sink_oe));
	lsd_host_model lsd_host_model_inst (.mclk(mclk), .ser_out(ser_out),
		.ser_clk(ser_clk), .ser_in(ser_in));
	task automatic complete_run();
		if (fails == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic pulse_load();
		@(negedge mclk) latch_load = 1'b1;
		repeat (4) @(negedge mclk);
		latch_load = 1'b0;
		repeat (6) @(negedge mclk);
	endtask
	task automatic t_chain();
		lsd_host_model_inst.send(16'hA5C3);
		lsd_host_model_inst.send(16'h3C96);
		`CHK(lsd_host_model_inst.seen, 16'hA5C3)
	endtask
	task automatic t_latch();
		pulse_load();
		`CHK(sink_oe, 16'h3C96)
		`CHK(sink_o, 16'h0000)
	endtask
	task automatic t_hold();
		lsd_host_model_inst.send(16'h8001);
		`CHK(sink_oe, 16'h3C96)
	endtask
	task automatic t_gate();
		@(negedge mclk) out_gate_n = 1'b1;
		repeat (5) @(negedge mclk);
		`CHK(sink_oe, 16'h0000)
		lsd_host_model_inst.send(16'h0FF0);
		pulse_load();
		`CHK(sink_oe, 16'h0000)
		`CHK(lsd_host_model_inst.seen, 16'h8001)
		out_gate_n = 1'b0;
		repeat (5) @(negedge mclk);
		`CHK(sink_oe, 16'h0FF0)
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		#200000;
		fails++;
		complete_run();
	end
	initial begin
		nrst = 1'b0;
		latch_load = 1'b0;
		out_gate_n = 1'b0;
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
		`CHK(sink_oe, 16'h0000)
		`CHK(ser_out, 1'b0)
		t_chain();
		t_latch();
		t_hold();
		t_gate();
		complete_run();
	end
endmodule
